// File: src/sldc_regs.svh
// Purpose: offsets, field positions, reset values and timing of the supply level detector
// Assumes: 10 MHz system clock
// Notes:   offsets are register indices on the plain register port
`ifndef SLDC_REGS_SVH
`define SLDC_REGS_SVH
`define SLDC_ADDR_W          3
`define SLDC_OFF_CONTROL     3'h0
`define SLDC_OFF_STATUS      3'h1
`define SLDC_OFF_IRQ_STATUS  3'h2
`define SLDC_OFF_IRQ_MASK    3'h3
`define SLDC_CTL_RANGE_BIT   3
`define SLDC_CTL_TRIM_LSB    0
`define SLDC_ST_BELOW_BIT    2
`define SLDC_ST_READY_BIT    1
`define SLDC_ST_ON_BIT       0
`define SLDC_CTL_RESET       8'h00
`define SLDC_ST_RESET        8'h00
`define SLDC_MASK_RESET      8'h00
`define SLDC_MEAS_TIME_US    2000
`define SLDC_CLK_MHZ         10
`define SLDC_MEAS_CYCLES     (`SLDC_MEAS_TIME_US * `SLDC_CLK_MHZ)
`define SLDC_MEAS_MAX_US     2500
`define SLDC_MEAS_MAX_CYCLES (`SLDC_MEAS_MAX_US * `SLDC_CLK_MHZ)
`define SLDC_IRQ_BELOW_BIT   0
`define SLDC_IRQ_READY_BIT   1
`endif

// File: src/sldc_pkg.sv
// Purpose: types of the supply level detector control
// Assumes: nothing
// Notes:   constants live in sldc_regs.svh
package sldc_pkg;
  typedef enum logic [1:0] {
    SLDC_OFF   = 2'b00,
    SLDC_MEAS  = 2'b01,
    SLDC_READY = 2'b10
  } sldc_state_t;
endpackage

// File: src/sldc_timer_if.sv
// Purpose: link between detector control and its measurement timer
// Assumes: one clock
// Notes:   start restarts the count; done is a one-cycle pulse
`timescale 1ns/1ps
interface sldc_timer_if;
  logic start;
  logic clear;
  logic done;
  modport ctrl  (output start, output clear, input done);
  modport timer (input start, input clear, output done);
endinterface

// File: src/sldc_meas_timer.sv
// Purpose: counts the settling time of one measurement
// Assumes: start and clear from the controller
// Notes:   count is a parameter so simulations can shorten it
`timescale 1ns/1ps
module sldc_meas_timer #(
  parameter int unsigned CYCLES = 20000
) (
  input  wire logic      clk_i,
  input  wire logic      rstn_i,
  sldc_timer_if.timer    tmr
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_r;
  logic          run_r;
  logic          done_r;

  assign tmr.done = done_r;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r  <= '0;
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end else if (tmr.clear) begin
      cnt_r  <= '0;
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end else if (tmr.start) begin
      cnt_r  <= CW'(CYCLES - 1);
      run_r  <= 1'b1;
      done_r <= 1'b0;
    end else if (run_r && cnt_r == '0) begin
      run_r  <= 1'b0;
      done_r <= 1'b1;
    end else begin
      cnt_r  <= run_r ? cnt_r - 1'b1 : cnt_r;
      done_r <= 1'b0;
    end
  end
endmodule // sldc_meas_timer

// File: src/sldc_top.sv
// Contract
// - enable bit switches detector on or off
// - ready flag rises 2 ms after start
// - interrupt only when ready and enabled; pending events keep it up after ready or enable drops, until read
// - one event per rising below-threshold edge
// - status bit 2 shows below, reset 0
// - status bit 1 shows ready, reset 0
// - three-bit trim selects one of eight
// - control bit 3 selects detection range
// - measurement lasts 2.0 ms, under 2.5
//
// Purpose: control and status logic of the supply level detector
// Assumes: 10 MHz clock, comparator output synchronous, register port
// Notes:   comparator itself is outside; this block drives its controls
`timescale 1ns/1ps
`include "sldc_regs.svh"
module sldc_top #(
  parameter int unsigned MEAS_CYCLES = `SLDC_MEAS_CYCLES
) (
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  input  wire logic [`SLDC_ADDR_W-1:0] addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [7:0]             rdata_o,
  input  wire logic                   comp_below_i,
  output logic                        detector_on_o,
  output logic                        detect_range_select_o,
  output logic      [2:0]             threshold_trim_o,
  output logic                        low_supply_irq_o
);
  //////////////////////////////////////////////////////////////////////////////
  logic [7:0]          ctl_r;
  logic                on_r;
  sldc_pkg::sldc_state_t state_r;
  logic                below_r;
  logic                below_d_r;
  logic [1:0]          irq_st_r;
  logic [1:0]          irq_mask_r;
  logic [7:0]          rdata_r;
  logic                ready;
  logic                below_rise;
  logic                ready_rise;
  logic                wr_ctl;
  logic                wr_st;
  logic                wr_mask;
  logic                rd_irq;

  sldc_timer_if tmr_if ();

  sldc_meas_timer #(
    .CYCLES (MEAS_CYCLES)
  ) u_timer (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .tmr    (tmr_if.timer)
  );

  assign wr_ctl  = wr_i && addr_i == `SLDC_OFF_CONTROL;
  assign wr_st   = wr_i && addr_i == `SLDC_OFF_STATUS;
  assign wr_mask = wr_i && addr_i == `SLDC_OFF_IRQ_MASK;
  assign rd_irq  = rd_i && addr_i == `SLDC_OFF_IRQ_STATUS;

  //////////////////////////////////////////////////////////////////////////////
  // control register: range and trim, upper bits reserved
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctl_r <= `SLDC_CTL_RESET;
    end else if (wr_ctl) begin
      ctl_r <= {4'h0, wdata_i[3:0]};
    end
  end

  assign detect_range_select_o = ctl_r[`SLDC_CTL_RANGE_BIT];
  assign threshold_trim_o      = ctl_r[`SLDC_CTL_TRIM_LSB +: 3];

  //////////////////////////////////////////////////////////////////////////////
  // enable: a write of 1 while already on restarts the measurement
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      on_r <= 1'b0;
    end else if (wr_st) begin
      on_r <= wdata_i[`SLDC_ST_ON_BIT];
    end
  end

  assign detector_on_o = on_r;
  assign tmr_if.start  = wr_st && wdata_i[`SLDC_ST_ON_BIT];
  assign tmr_if.clear  = wr_st && !wdata_i[`SLDC_ST_ON_BIT];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= sldc_pkg::SLDC_OFF;
    end else begin
      unique case (state_r)
        sldc_pkg::SLDC_OFF: begin
          if (tmr_if.start) begin
            state_r <= sldc_pkg::SLDC_MEAS;
          end
        end
        sldc_pkg::SLDC_MEAS: begin
          if (tmr_if.clear) begin
            state_r <= sldc_pkg::SLDC_OFF;
          end else if (tmr_if.done && !tmr_if.start) begin
            state_r <= sldc_pkg::SLDC_READY;
          end
        end
        sldc_pkg::SLDC_READY: begin
          if (tmr_if.clear) begin
            state_r <= sldc_pkg::SLDC_OFF;
          end else if (tmr_if.start) begin
            state_r <= sldc_pkg::SLDC_MEAS;
          end
        end
        default: state_r <= sldc_pkg::SLDC_OFF;
      endcase
    end
  end

  assign ready = state_r == sldc_pkg::SLDC_READY;

  //////////////////////////////////////////////////////////////////////////////
  // result: held at 0 from the cycle after ready ends, so stale comparator output shows for at most that one cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      below_r   <= 1'b0;
      below_d_r <= 1'b0;
    end else begin
      below_r   <= ready && comp_below_i;
      below_d_r <= below_r;
    end
  end

  assign below_rise = below_r && !below_d_r && ready;
  assign ready_rise = tmr_if.done && state_r == sldc_pkg::SLDC_MEAS && !tmr_if.start
                      && !tmr_if.clear;

  //////////////////////////////////////////////////////////////////////////////
  // sticky events, cleared by reading them; a new event wins over the clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_st_r <= 2'b00;
    end else begin
      irq_st_r[`SLDC_IRQ_BELOW_BIT] <= below_rise ||
                                       (irq_st_r[`SLDC_IRQ_BELOW_BIT] && !rd_irq);
      irq_st_r[`SLDC_IRQ_READY_BIT] <= ready_rise ||
                                       (irq_st_r[`SLDC_IRQ_READY_BIT] && !rd_irq);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_mask_r <= 2'b00;
    end else if (wr_mask) begin
      irq_mask_r <= wdata_i[1:0];
    end
  end

  assign low_supply_irq_o = |(irq_st_r & irq_mask_r);

  //////////////////////////////////////////////////////////////////////////////
  // read port; unmapped addresses read zero
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_r <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        `SLDC_OFF_CONTROL:    rdata_r <= ctl_r;
        `SLDC_OFF_STATUS:     rdata_r <= {5'h00, below_r, ready, on_r};
        `SLDC_OFF_IRQ_STATUS: rdata_r <= {6'h00, irq_st_r};
        `SLDC_OFF_IRQ_MASK:   rdata_r <= {6'h00, irq_mask_r};
        default:              rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign rdata_o = rdata_r;

  //////////////////////////////////////////////////////////////////////////////
  sequence s_enable;
    tmr_if.start;
  endsequence
  sequence s_quiet_run;
    !tmr_if.start && !tmr_if.clear;
  endsequence

  chk_ready_after_meas: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_enable ##1 s_quiet_run [*2] |-> !ready)
    else $error("ready rose too early after enable");

  chk_ready_timely: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tmr_if.done && state_r == sldc_pkg::SLDC_MEAS && !tmr_if.start && !tmr_if.clear
    |=> ready)
    else $error("ready did not follow timer done");

  chk_disable_clears: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tmr_if.clear |=> !ready && !on_r ##1 !below_r)
    else $error("disable did not clear ready and result");

  chk_enable_on: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_st |=> on_r == $past(wdata_i[0]))
    else $error("enable bit not taken");

  chk_event_once: assert property (@(posedge clk_i) disable iff (!rstn_i)
    below_rise |=> !below_rise)
    else $error("below event repeated");

  chk_event_gated: assert property (@(posedge clk_i) disable iff (!rstn_i)
    below_rise |-> ready && on_r)
    else $error("event outside ready window");

  chk_irq_level: assert property (@(posedge clk_i) disable iff (!rstn_i)
    below_rise && irq_mask_r[0] |=> low_supply_irq_o)
    else $error("masked-in event missed interrupt");

  chk_result_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !ready |=> !below_r)
    else $error("result shown while not ready");

  chk_trim_out: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_ctl |=> threshold_trim_o == $past(wdata_i[2:0])
               && detect_range_select_o == $past(wdata_i[3]))
    else $error("trim or range not applied");

  // a quiet run right after enable must sit in the measuring state
  chk_meas_holds: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_enable ##1 s_quiet_run [*3] |-> state_r == sldc_pkg::SLDC_MEAS)
    else $error("measurement left early");

  chk_ready_needs_on: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ready |-> on_r)
    else $error("ready while detector off");

  chk_set_wins: assert property (@(posedge clk_i) disable iff (!rstn_i)
    below_rise |=> irq_st_r[`SLDC_IRQ_BELOW_BIT])
    else $error("below event lost against clear");

  chk_read_clears: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_irq && !below_rise && !ready_rise |=> irq_st_r == 2'b00)
    else $error("irq status not cleared by read");

  chk_irq_masked: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_mask_r == 2'b00 |-> !low_supply_irq_o)
    else $error("interrupt raised while fully masked");

  chk_rdata_idle: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read cycle");

  chk_ctl_reserved: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ctl_r[7:4] == 4'h0)
    else $error("reserved control bits set");
endmodule // sldc_top

// File: dv/testbench.sv
// Purpose: self-checking bench of the supply level detector control
// Assumes: register port with read data in the cycle after the strobe
// Notes:   measurement count shortened to MC cycles to keep the run short
`timescale 1ns/1ps
`include "sldc_regs.svh"
module testbench;
  localparam int unsigned MC = 20;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } sldc_row_t;
  logic        clk_i        = 1'b0;
  logic        rstn_i       = 1'b0;
  logic [2:0]  addr_i       = 3'h0;
  logic [7:0]  wdata_i      = 8'h00;
  logic        wr_i         = 1'b0;
  logic        rd_i         = 1'b0;
  logic        comp_below_i = 1'b0;
  logic [7:0]  rdata_o;
  logic        detector_on_o;
  logic        detect_range_select_o;
  logic [2:0]  threshold_trim_o;
  logic        low_supply_irq_o;
  int          bad_count       = 0;
  int          samples_checked = 0;
  int          n;
  // last rows leave range 1 and trim 011 in place
  sldc_row_t   rows [10] = '{'{3'h0, 8'h08, 8'h08}, '{3'h0, 8'h09, 8'h09},
    '{3'h0, 8'h0A, 8'h0A}, '{3'h0, 8'h0C, 8'h0C}, '{3'h0, 8'h0D, 8'h0D},
    '{3'h0, 8'h0E, 8'h0E}, '{3'h0, 8'h07, 8'h07}, '{3'h5, 8'hFF, 8'h00},
    '{3'h3, 8'h03, 8'h03}, '{3'h0, 8'hFB, 8'h0B}};

  sldc_top #(.MEAS_CYCLES(MC)) u_sldc_top (
    .clk_i                 (clk_i),
    .rstn_i                (rstn_i),
    .addr_i                (addr_i),
    .wdata_i               (wdata_i),
    .wr_i                  (wr_i),
    .rd_i                  (rd_i),
    .rdata_o               (rdata_o),
    .comp_below_i          (comp_below_i),
    .detector_on_o         (detector_on_o),
    .detect_range_select_o (detect_range_select_o),
    .threshold_trim_o      (threshold_trim_o),
    .low_supply_irq_o      (low_supply_irq_o)
  );

  always #50 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    #1;
  endtask

  // data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask

  task automatic below_edge();
    @(posedge clk_i);
    comp_below_i <= 1'b0;
    @(posedge clk_i);
    comp_below_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic outs_zero();
    chk({2'b00, detector_on_o, detect_range_select_o, threshold_trim_o, low_supply_irq_o},
        8'h00);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1;
    outs_zero();
    for (int a = 0; a < 4; a++) rd(a[2:0], 8'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].rexp);
      if (rows[i].addr == `SLDC_OFF_CONTROL) begin
        chk({5'h00, threshold_trim_o}, {5'h00, rows[i].wdata[2:0]});
        chk({7'h00, detect_range_select_o}, {7'h00, rows[i].wdata[3]});
      end
    end
    $display("test table done");
    wr(`SLDC_OFF_STATUS, 8'h01);
    chk({7'h00, detector_on_o}, 8'h01);
    // an early dip must not count while the result is not yet trusted
    for (n = 0; n < MC + 50; n++) begin
      @(posedge clk_i);
      comp_below_i <= (n < 5);
      #1;
      if (low_supply_irq_o === 1'b1) break;
    end
    samples_checked++;
    if (n < MC - 1 || n > MC + 4) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, n, MC);
    end
    rd(`SLDC_OFF_IRQ_STATUS, 8'h02);
    rd(`SLDC_OFF_IRQ_STATUS, 8'h00);
    chk({7'h00, low_supply_irq_o}, 8'h00);
    rd(`SLDC_OFF_STATUS, 8'h03);
    $display("test ready done");
    below_edge();
    chk({7'h00, low_supply_irq_o}, 8'h01);
    rd(`SLDC_OFF_IRQ_STATUS, 8'h01);
    rd(`SLDC_OFF_IRQ_STATUS, 8'h00);
    rd(`SLDC_OFF_STATUS, 8'h07);
    wr(`SLDC_OFF_IRQ_MASK, 8'h02);
    below_edge();
    chk({7'h00, low_supply_irq_o}, 8'h00);
    wr(`SLDC_OFF_IRQ_MASK, 8'h03);
    chk({7'h00, low_supply_irq_o}, 8'h01);
    rd(`SLDC_OFF_IRQ_STATUS, 8'h01);
    $display("test events done");
    wr(`SLDC_OFF_STATUS, 8'h00);
    chk({7'h00, detector_on_o}, 8'h00);
    rd(`SLDC_OFF_STATUS, 8'h00);
    below_edge();
    rd(`SLDC_OFF_IRQ_STATUS, 8'h00);
    $display("test disable done");
    wr(`SLDC_OFF_STATUS, 8'h01);
    repeat (MC + 5) @(posedge clk_i);
    rstn_i <= 1'b0;
    @(posedge clk_i);
    #1;
    outs_zero();
    @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(`SLDC_OFF_STATUS, 8'h00);
    rd(`SLDC_OFF_CONTROL, 8'h00);
    $display("test second reset done");
    report_and_stop();
  end
endmodule // testbench
